// ---- rtl/acs_defs.svh ----
// Register offsets, field positions and reset values of the conversion sequencer
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_OFF_SETUP    8'h00
`define ACS_OFF_CTRL     8'h04
`define ACS_OFF_STATUS   8'h08
`define ACS_OFF_RIGHT    8'h40
`define ACS_OFF_LSIGNED  8'h60
`define ACS_OFF_LUNSIGN  8'h80
`define ACS_CTRL_CHAN_LO 0
`define ACS_CTRL_LEN_BIT 4
`define ACS_CTRL_MUL_BIT 5
`define ACS_CTRL_REP_BIT 6
`define ACS_CTRL_RESET   7'h00
`define ACS_SETUP_RESET  8'h03
`define ACS_STAT_SEQ_BIT 8
`endif

// ---- rtl/acs_pkg.sv ----
// Types shared by the conversion sequencer files
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_START,
    ACS_WAIT
  } acs_state_t;
  typedef logic [2:0] acs_mode_t;
endpackage : acs_pkg

// ---- rtl/acs_result_view.sv ----
// Formats one stored result into the three read views
`timescale 1ns/1ns
`default_nettype none
module acs_result_view #(
  parameter int RES_W = 10
) (
  input  wire logic [RES_W-1:0] result,
  input  wire logic [1:0]       viewSel,
  output logic      [15:0]      viewData
);
  // Right unsigned, left signed (MSB flipped), left unsigned
  wire logic [15:0] rightU = {{(16-RES_W){1'b0}}, result};
  wire logic [15:0] leftU  = {result, {(16-RES_W){1'b0}}};
  wire logic [15:0] leftS  = {~result[RES_W-1], result[RES_W-2:0], {(16-RES_W){1'b0}}};
  assign viewData = (viewSel == 2'h0) ? rightU :
                    (viewSel == 2'h1) ? leftS : leftU;
endmodule : acs_result_view
`default_nettype wire

// ---- rtl/acs_channel_map.sv ----
// Works out the input and result slot for a step of the sequence
`timescale 1ns/1ns
`default_nettype none
module acs_channel_map (
  input  wire logic [3:0] channelSelect,
  input  wire logic       multiChannel,
  input  wire logic       eightLength,
  input  wire logic [2:0] step,
  output logic      [3:0] inputSel,
  output logic      [2:0] slot
);
  // Group base drops the low select bits in multi-channel modes
  wire logic [3:0] groupBase = eightLength ? {channelSelect[3], 3'h0}
                                           : {channelSelect[3:2], 2'h0};
  // Ascending order in multi-channel modes: step k is input base+k into slot k
  assign inputSel = multiChannel ? (groupBase | {1'b0, step}) : channelSelect;
  assign slot     = step;
endmodule : acs_channel_map
`default_nettype wire

// ---- rtl/acs_sequencer.sv ----
// Conversion mode sequencer with Wishbone registers and result slots
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.svh"
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int RES_W = 10
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             clkEn,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  convStart,
  output logic      [3:0]       convInput,
  input  wire logic             convDone,
  input  wire logic [RES_W-1:0] convResult
);
  // Register state
  logic [6:0]       conversionControl;
  logic [7:0]       converterSetup;
  logic [7:0]       slotCompleteFlags;
  logic             sequenceCompleteFlag;
  logic [RES_W-1:0] resultSlot [8];
  acs_state_t       state;
  logic [2:0]       step;
  logic             firstPass;

  // Bus decode; byte lane 0 must be enabled for control writes
  wire logic       busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic       wrLow    = busReq & wb_we_i & wb_sel_i[0];
  wire logic       wrCtrl   = wrLow & (wb_adr_i == `ACS_OFF_CTRL);
  wire logic       wrSetup  = wrLow & (wb_adr_i == `ACS_OFF_SETUP);
  wire logic [2:0] rdSlot   = wb_adr_i[4:2];
  wire logic       hitRight = wb_adr_i[7:5] == 3'(`ACS_OFF_RIGHT >> 5);
  wire logic       hitLs    = wb_adr_i[7:5] == 3'(`ACS_OFF_LSIGNED >> 5);
  wire logic       hitLu    = wb_adr_i[7:5] == 3'(`ACS_OFF_LUNSIGN >> 5);
  wire logic       slotWord = (hitRight | hitLs | hitLu) & (wb_adr_i[1:0] == 2'h0)
                              & (wb_adr_i[4:2] <= 3'h7);
  wire logic [1:0] viewSel  = hitRight ? 2'h0 : (hitLs ? 2'h1 : 2'h2);

  // Mode decode from the three control bits
  wire acs_mode_t  mode     = {conversionControl[`ACS_CTRL_REP_BIT],
                               conversionControl[`ACS_CTRL_MUL_BIT],
                               conversionControl[`ACS_CTRL_LEN_BIT]};
  wire logic       repeatOn = mode[2];
  wire logic       multiOn  = mode[1];
  wire logic       eightOn  = mode[0];
  wire logic [2:0] lastStep = eightOn ? 3'h7 : 3'h3;
  wire logic       atLast   = step == lastStep;

  logic [3:0] mapInput;
  logic [2:0] mapSlot;
  logic [15:0] viewData;

  acs_channel_map u_map (
    .channelSelect (conversionControl[3:0]),
    .multiChannel  (multiOn),
    .eightLength   (eightOn),
    .step          (step),
    .inputSel      (mapInput),
    .slot          (mapSlot)
  );

  acs_result_view #(.RES_W(RES_W)) u_view (
    .result   (resultSlot[rdSlot]),
    .viewSel  (viewSel),
    .viewData (viewData)
  );

  // Read data mux; unmapped addresses read zero but still ack
  wire logic [31:0] rdData =
    (wb_adr_i == `ACS_OFF_SETUP)  ? {24'h0, converterSetup} :
    (wb_adr_i == `ACS_OFF_CTRL)   ? {25'h0, conversionControl} :
    (wb_adr_i == `ACS_OFF_STATUS) ? {23'h0, sequenceCompleteFlag, slotCompleteFlags} :
    slotWord                      ? {16'h0, viewData} : 32'h0;

  // A done seen while our start pulse still stands belongs to an aborted
  // conversion: the far side cannot have answered the new start yet
  wire logic doneTaken = convDone & ~convStart;

  // Result arrives for the slot currently converting
  wire logic storeNow = (state == ACS_WAIT) & doneTaken & ~wrCtrl & ~wrSetup;

  // Bus answer: one cycle after the request is seen
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clkEn) begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : 32'h0;
    end
  end

  // Control and setup registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conversionControl <= `ACS_CTRL_RESET;
      converterSetup    <= `ACS_SETUP_RESET;
    end else if (clkEn) begin
      if (wrCtrl) conversionControl <= wb_dat_i[6:0];
      if (wrSetup) converterSetup <= wb_dat_i[7:0];
    end
  end

  // Sequence state machine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ACS_IDLE;
      step      <= 3'h0;
      firstPass <= 1'b0;
      convStart <= 1'b0;
      convInput <= 4'h0;
    end else if (clkEn) begin
      convStart <= 1'b0;
      if (wrSetup) begin
        state <= ACS_IDLE;
      end else if (wrCtrl) begin
        state     <= ACS_START;
        step      <= 3'h0;
        firstPass <= 1'b1;
      end else begin
        unique case (state)
          ACS_IDLE: ;
          ACS_START: begin
            // Reserved codes run like any other input
            convInput <= mapInput;
            convStart <= 1'b1;
            state     <= ACS_WAIT;
          end
          ACS_WAIT: if (doneTaken) begin
            if (atLast) begin
              firstPass <= 1'b0;
              step      <= 3'h0;
              state     <= repeatOn ? ACS_START : ACS_IDLE;
            end else begin
              step  <= step + 3'h1;
              state <= ACS_START;
            end
          end
        endcase
      end
    end
  end

  // Result slots; repeating passes simply overwrite
  always_ff @(posedge sys_clk) begin
    if (clkEn && storeNow) resultSlot[mapSlot] <= convResult;
  end

  // Flags: aborting write clears, a store sets
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slotCompleteFlags    <= 8'h00;
      sequenceCompleteFlag <= 1'b0;
    end else if (clkEn) begin
      if (wrCtrl || wrSetup) begin
        slotCompleteFlags    <= 8'h00;
        sequenceCompleteFlag <= 1'b0;
      end else if (storeNow) begin
        slotCompleteFlags[mapSlot] <= 1'b1;
        if (atLast && firstPass) sequenceCompleteFlag <= 1'b1;
      end
    end
  end
endmodule : acs_sequencer
`default_nettype wire

// ---- sim/acs_sequencer_chk.sv ----
// Port checker for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.svh"
module acs_sequencer_chk #(parameter int RES_W = 10) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic convStart,
  input wire logic [3:0] convInput,
  input wire logic convDone,
  input wire logic [RES_W-1:0] convResult
);
  // Taken requests and register writes
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire ctrlWr = wr && wb_adr_i == `ACS_OFF_CTRL;
  wire setupWr = wr && wb_adr_i == `ACS_OFF_SETUP;
  logic [6:0] ctrl;
  logic halted;
  // Shadow of control; halted until a control write, as after reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 7'h00;
      halted <= 1'b1;
    end else if (ctrlWr) begin
      ctrl <= wb_dat_i[6:0];
      halted <= 1'b0;
    end else if (setupWr) begin
      halted <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_ack_taken: assert property (req |=> wb_ack_o) else $error("no ack");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  chk_ctrl_restart: assert property (ctrlWr |-> ##2 convStart) else $error("no restart");
  chk_start_gap: assert property (convStart |=> !convStart) else $error("start gap");
  chk_input_hold: assert property (!convStart |-> $stable(convInput)) else $error("input moved");
  chk_setup_halt: assert property ($past(halted) && halted |-> !convStart) else $error("halt");
  chk_single_code: assert property (convStart && !ctrl[5] |-> convInput == ctrl[3:0])
    else $error("single input");
  chk_group_base: assert property (convStart && ctrl[5] |-> (ctrl[4] ? convInput[3] == ctrl[3]
    : convInput[3:2] == ctrl[3:2])) else $error("group base");
  cover property (ctrlWr ##2 convStart);
  cover property (convStart && ctrl[6] && ctrl[5]);
  cover property (setupWr);
endmodule : acs_sequencer_chk
bind acs_sequencer acs_sequencer_chk #(.RES_W(RES_W)) u_chk (.*);
`default_nettype wire

// ---- sim/acs_analog_model.sv ----
// Analog side model: one conversion at a time, answer lat+1 cycles after the start is seen
`timescale 1ns/1ns
`default_nettype none
module acs_analog_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic convStart,
  input wire logic [3:0] convInput,
  input wire logic [2:0] lat,
  output logic convDone,
  output logic [9:0] convResult
);
  logic [2:0] cnt;
  logic busy;
  // New start drops any conversion in flight; result toggles when not valid
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      convDone <= 1'b0;
      convResult <= 10'h000;
      busy <= 1'b0;
      cnt <= 3'h0;
    end else begin
      convDone <= 1'b0;
      convResult <= ~convResult;
      if (convStart) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt == 3'h0) begin
        busy <= 1'b0;
        convDone <= 1'b1;
        convResult <= {convInput, 2'b10, ~convInput};
      end else if (busy) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
endmodule : acs_analog_model
`default_nettype wire

// ---- sim/acs_sequencer_tb.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_tb;
  logic sys_clk = 0, arst_n = 0, clkEn = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF, convInput, ch, ci;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, convStart, convDone;
  logic [9:0] convResult;
  logic [2:0] lat = 3'h1, m;
  logic [32:0] expQ[$], head;
  int n_fail = 0, compares = 0, seed = 32'h31f3809f;
  always #4 sys_clk = ~sys_clk;
  acs_sequencer dut (.*);
  acs_analog_model model (.*);
  // Classic single cycle, held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task rdc(input logic [7:0] a, input logic c, input logic [31:0] e);
    expQ.push_back({c, e});
    bus(1'b0, a, 32'h0);
  endtask : rdc
  function logic [9:0] res(input logic [3:0] i);
    return {i, 2'b10, ~i};
  endfunction : res
  // Read answers against the oldest note
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      head = expQ.pop_front();
      if (head[32]) compares++;
      if (head[32] && wb_dat_o !== head[31:0]) begin
        n_fail++;
        $display("mismatch t=%0t got %h exp %h", $time, wb_dat_o, head[31:0]);
      end
    end
  end
  task results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // All eight modes, each after an aborted start, then a halt
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(8'h00, 1'b1, 32'h3);
    rdc(8'h0C, 1'b1, 32'h0);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      ch = 4'($random(seed));
      lat <= 3'($random(seed));
      bus(1'b1, 8'h04, {25'h0, ~m, ch});
      bus(1'b1, 8'h04, {25'h0, m, ch});
      do rdc(8'h08, 1'b0, 32'h0); while (rd[8] !== 1'b1);
      rdc(8'h08, 1'b1, m[0] ? 32'h1FF : 32'h10F);
      for (int k = 0; k < (m[0] ? 8 : 4); k++) begin
        ci = !m[1] ? ch : m[0] ? {ch[3], k[2:0]} : {ch[3:2], k[1:0]};
        rdc(8'(8'h40 + 4 * k), 1'b1, res(ci));
        rdc(8'(8'h60 + 4 * k), 1'b1, {res(ci), 6'h0} ^ 16'h8000);
        rdc(8'(8'h80 + 4 * k), 1'b1, {res(ci), 6'h0});
      end
      bus(1'b1, 8'h00, 32'h3);
      rdc(8'h08, 1'b1, 32'h0);
      $display("mode %0d done", m);
    end
    // Reset in mid-run, with a sequence in flight
    bus(1'b1, 8'h04, 32'h7F);
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(8'h08, 1'b1, 32'h0);
    rdc(8'h04, 1'b1, 32'h0);
    rdc(8'h00, 1'b1, 32'h3);
    $display("reset test done");
    results();
  end
  // Hang guard, far beyond the thousand or so cycles needed
  initial begin
    #160000;
    n_fail++;
    results();
  end
endmodule : acs_sequencer_tb
`default_nettype wire
